// [src/rsq_pkg.sv]
// Purpose: Shared constants and types for the recipe select queue.
// Assumes: 20 MHz clk, synchronous active-low reset.
// Notes: Functional notes follow.
// Functional notes
// - The nine select lines are read as two decimal digits of four weighted lines each and one hundreds line.
// - Line weights are 1, 2, 4, 8, 10, 20, 40, 80 and 100; the number is the sum of active weights.
// - A strobed number reaches only applicators whose mask line is high; others keep their queue.
// - A strobed entry is accepted whatever mode an applicator is in.
// - Each of eight applicators has a one-deep queue, filled only while it executes a recipe or is in an auxiliary mode.
// - A new number overwrites a full queue entry and the old one is lost.
// - After a halt, the first run pulse makes the queued number current and empties the queue.
// - The trigger input never touches a queue.
// - A run with an empty queue restarts with the most recently entered number.
// - A halt stops the current recipe but keeps its number for a later run.
// - Pulsed inputs are held at least 0.25 s; the device acts once on the edge only.
package rsq_pkg;
    localparam int NUM_APPS = 8;
    localparam int SEL_W = 9;
    localparam int REC_W = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_LAST = 8'h08;
    localparam logic [7:0] OFF_APP_BASE = 8'h20;
    localparam logic [7:0] OFF_APP_LAST = 8'h3c;

    // Field positions.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STATUS_QUEUED_LSB = 8;
    localparam int APP_NEXT_LSB = 16;

    // Values after reset.
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic [9:0] RECIPE_RESET = 10'h000;

    // Decimal digit weights of the upper line groups.
    localparam logic [9:0] WEIGHT_TENS = 10'h00a;
    localparam logic [9:0] WEIGHT_HUNDREDS = 10'h064;

    typedef logic [REC_W-1:0] rsq_recipe_t;

    typedef enum {
        RSQ_IDLE,
        RSQ_RUNNING,
        RSQ_HALTED
    } rsq_app_state_t;

    // Register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rsq_bus_req_t;

    // Per-applicator status seen by the rest of the controller.
    typedef struct packed {
        logic running;
        logic queued;
        rsq_recipe_t current;
        rsq_recipe_t next;
    } rsq_app_status_t;
endpackage

// [src/rsq_recipe_select_queue.sv]
// Purpose: Discrete recipe select port with a one-deep queue per applicator.
// Assumes: Host lines are slow levels; run and halt arrive as pulses per applicator.
// Notes: Load, clean and calibrate modes are reported by aux_mode_active.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module rsq_recipe_select_queue (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input rsq_pkg::rsq_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Host discrete inputs
    input wire logic [8:0] recipe_code_input,
    input wire logic [7:0] applicator_mask_input,
    input wire logic recipe_latch_pulse,
    input wire logic [7:0] run_pulse_input,
    input wire logic [7:0] halt_pulse_input,
    input wire logic [7:0] aux_mode_active,
    // Applicator status
    output rsq_pkg::rsq_app_status_t [7:0] app_status
);

    localparam int IN_W = 42;

    logic [IN_W-1:0] in_raw;
    logic [IN_W-1:0] sync1_reg;
    logic [IN_W-1:0] sync2_reg;
    logic [16:0] pulse_prev_reg;
    logic [8:0] sel_s;
    logic [7:0] mask_s;
    logic strobe_s;
    logic [7:0] run_s;
    logic [7:0] halt_s;
    logic [7:0] aux_s;
    logic strobe_edge;
    logic [7:0] run_edge;
    logic [7:0] halt_edge;
    logic [9:0] code_num;
    logic [9:0] last_code_reg;
    logic enable_reg;
    logic [7:0] accept;
    logic [7:0] run_take;
    logic [7:0] exec_after;
    rsq_pkg::rsq_app_state_t state_reg [8];
    logic [7:0] running;
    logic [7:0] queued_reg;
    rsq_pkg::rsq_recipe_t current_reg [8];
    rsq_pkg::rsq_recipe_t next_reg [8];
    rsq_pkg::rsq_recipe_t last_reg [8];
    logic [31:0] rdata_next;

    // Every host line goes through two flops; host timing is unknown.
    // The price is two cycles of latency, far below any host pulse width.
    assign in_raw = {recipe_code_input, applicator_mask_input, recipe_latch_pulse,
                     run_pulse_input, halt_pulse_input, aux_mode_active};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= in_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Only the second stage is decoded.
    assign sel_s = sync2_reg[41:33];
    assign mask_s = sync2_reg[32:25];
    assign strobe_s = sync2_reg[24];
    assign run_s = sync2_reg[23:16];
    assign halt_s = sync2_reg[15:8];
    assign aux_s = sync2_reg[7:0];

    // Previous levels of the pulsed lines.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pulse_prev_reg <= '0;
        end else begin
            pulse_prev_reg <= {strobe_s, run_s, halt_s};
        end
    end

    // A held pulse acts once; the level after the edge is ignored.
    assign strobe_edge = strobe_s & ~pulse_prev_reg[16];
    assign run_edge = run_s & ~pulse_prev_reg[15:8];
    assign halt_edge = halt_s & ~pulse_prev_reg[7:0];

    // Digits are summed by weight, so out-of-range digit codes still add up.
    // The sum spans 0 to 265 and is not clamped; keeping digits valid is the host's job.
    assign code_num = 10'(sel_s[3:0])
                    + 10'(10'(sel_s[7:4]) * rsq_pkg::WEIGHT_TENS)
                    + (sel_s[8] ? rsq_pkg::WEIGHT_HUNDREDS : 10'h000);

    // Number captured on the strobe edge, same cycle as the mask.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_code_reg <= rsq_pkg::RECIPE_RESET;
        end else if (strobe_edge) begin
            last_code_reg <= code_num;
        end
    end

    // Control register; software may block host entries.
    // A blocked entry is still captured as the last number, which helps when tracing a host.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            enable_reg <= rsq_pkg::CTRL_ENABLE_RESET;
        end else if (bus_req.wr && bus_req.addr == rsq_pkg::OFF_CTRL) begin
            enable_reg <= bus_req.wdata[rsq_pkg::CTRL_ENABLE_BIT];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < rsq_pkg::NUM_APPS; gi++) begin : g_app
            // Mask selects the receivers; mode does not matter.
            assign accept[gi] = strobe_edge & mask_s[gi] & enable_reg;
            assign running[gi] = (state_reg[gi] == rsq_pkg::RSQ_RUNNING);
            // Halt wins over a run in the same cycle, the safer outcome.
            assign run_take[gi] = run_edge[gi] & ~halt_edge[gi] & ~running[gi];
            // Executing state as it stands after this cycle's run or halt.
            assign exec_after[gi] = run_take[gi]
                                  | (running[gi] & ~halt_edge[gi])
                                  | aux_s[gi];

            // Run state; only run and halt move it, never the trigger.
            // A halt from idle parks the applicator in halted; its numbers are untouched.
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    state_reg[gi] <= rsq_pkg::RSQ_IDLE;
                end else begin
                    case (state_reg[gi])
                        rsq_pkg::RSQ_IDLE,
                        rsq_pkg::RSQ_HALTED: begin
                            if (halt_edge[gi]) begin
                                state_reg[gi] <= rsq_pkg::RSQ_HALTED;
                            end else if (run_edge[gi]) begin
                                state_reg[gi] <= rsq_pkg::RSQ_RUNNING;
                            end
                        end
                        rsq_pkg::RSQ_RUNNING: begin
                            if (halt_edge[gi]) begin
                                state_reg[gi] <= rsq_pkg::RSQ_HALTED;
                            end
                        end
                        default: begin
                            state_reg[gi] <= rsq_pkg::RSQ_IDLE;
                        end
                    endcase
                end
            end

            // Current, queued and last-entered numbers.
            // The run branch comes first, so an entry in the same cycle sets the queue flag last.
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    current_reg[gi] <= rsq_pkg::RECIPE_RESET;
                    next_reg[gi] <= rsq_pkg::RECIPE_RESET;
                    last_reg[gi] <= rsq_pkg::RECIPE_RESET;
                    queued_reg[gi] <= 1'b0;
                end else begin
                    if (run_take[gi]) begin
                        if (queued_reg[gi]) begin
                            current_reg[gi] <= next_reg[gi];
                        end else begin
                            current_reg[gi] <= last_reg[gi];
                        end
                        queued_reg[gi] <= 1'b0;
                    end
                    // An entry in the run cycle lands behind the promoted one.
                    if (accept[gi]) begin
                        last_reg[gi] <= code_num;
                        if (exec_after[gi]) begin
                            next_reg[gi] <= code_num;
                            queued_reg[gi] <= 1'b1;
                        end else begin
                            current_reg[gi] <= code_num;
                            queued_reg[gi] <= 1'b0;
                        end
                    end
                end
            end

            // Queued, current and next are straight copies of flops; running is decoded from state_reg.
            assign app_status[gi].running = running[gi];
            assign app_status[gi].queued = queued_reg[gi];
            assign app_status[gi].current = current_reg[gi];
            assign app_status[gi].next = next_reg[gi];

            // Each check looks one cycle past the event that it guards.
            chk_queue_overwrite: assert property (@(posedge clk) disable iff (!resetn)
                accept[gi] && exec_after[gi] |=> queued_reg[gi] && next_reg[gi] == $past(code_num))
                else $error("queued entry not replaced by new number");

            chk_direct_load: assert property (@(posedge clk) disable iff (!resetn)
                accept[gi] && !exec_after[gi] |=> !queued_reg[gi] && current_reg[gi] == $past(code_num))
                else $error("idle applicator did not load number as current");

            chk_mask_gate: assert property (@(posedge clk) disable iff (!resetn)
                strobe_edge && !mask_s[gi] && !run_take[gi] |=> $stable(next_reg[gi]) && $stable(queued_reg[gi]))
                else $error("unmasked applicator queue changed");

            chk_run_promote: assert property (@(posedge clk) disable iff (!resetn)
                run_take[gi] && queued_reg[gi] && !accept[gi]
                |=> current_reg[gi] == $past(next_reg[gi]) && !queued_reg[gi] && running[gi])
                else $error("run did not promote queued number");

            chk_run_default: assert property (@(posedge clk) disable iff (!resetn)
                run_take[gi] && !queued_reg[gi] |=> current_reg[gi] == $past(last_reg[gi]))
                else $error("run with empty queue did not reuse last number");

            chk_halt_keep: assert property (@(posedge clk) disable iff (!resetn)
                halt_edge[gi] && !accept[gi] |=> !running[gi] && $stable(current_reg[gi]))
                else $error("halt lost current number or kept running");

            chk_run_once: assert property (@(posedge clk) disable iff (!resetn)
                run_edge[gi] |=> !run_edge[gi])
                else $error("run pulse acted twice");

            chk_idle_no_queue: assert property (@(posedge clk) disable iff (!resetn)
                !running[gi] && !aux_s[gi] && !run_take[gi] && !queued_reg[gi] |=> !queued_reg[gi])
                else $error("queue filled while not executing");

            // The queue moves only on an entry or a run; no other input, the trigger included, reaches it.
            chk_queue_quiet: assert property (@(posedge clk) disable iff (!resetn)
                !accept[gi] && !run_take[gi] |=> $stable(next_reg[gi]) && $stable(queued_reg[gi]))
                else $error("queue changed without an entry or a run");

            // A refused entry, blocked or unmasked, must leave the current and last numbers of this applicator alone.
            chk_entry_block: assert property (@(posedge clk) disable iff (!resetn)
                strobe_edge && !accept[gi] && !run_take[gi]
                |=> $stable(current_reg[gi]) && $stable(last_reg[gi]))
                else $error("refused entry changed applicator numbers");

            chk_last_entry: assert property (@(posedge clk) disable iff (!resetn)
                accept[gi] |=> last_reg[gi] == $past(code_num))
                else $error("last entered number not recorded");

            // An auxiliary mode counts as executing even while the run state is idle.
            chk_aux_queue: assert property (@(posedge clk) disable iff (!resetn)
                accept[gi] && aux_s[gi] |=> queued_reg[gi] && next_reg[gi] == $past(code_num))
                else $error("entry in auxiliary mode not queued");

            chk_run_start: assert property (@(posedge clk) disable iff (!resetn)
                run_take[gi] |=> running[gi])
                else $error("run pulse did not start applicator");

            chk_halt_state: assert property (@(posedge clk) disable iff (!resetn)
                halt_edge[gi] |=> state_reg[gi] == rsq_pkg::RSQ_HALTED)
                else $error("halt did not reach halted state");

            chk_halt_once: assert property (@(posedge clk) disable iff (!resetn)
                halt_edge[gi] |=> !halt_edge[gi])
                else $error("halt pulse acted twice");
        end
    endgenerate

    chk_strobe_once: assert property (@(posedge clk) disable iff (!resetn)
        strobe_edge |=> !strobe_edge [*2])
        else $error("strobe acted more than once");

    chk_sync_delay: assert property (@(posedge clk) disable iff (!resetn)
        ##2 strobe_s == $past(recipe_latch_pulse, 2))
        else $error("strobe not delayed by two stages");

    chk_bcd_decode: assert property (@(posedge clk) disable iff (!resetn)
        strobe_edge |=> last_code_reg == 10'($past(sel_s[3:0])) + 10'($past(sel_s[7:4])) * 10'h00a
                        + ($past(sel_s[8]) ? 10'h064 : 10'h000))
        else $error("captured number does not match line weights");

    // Every host line, not only the strobe, sits exactly two stages behind its pin.
    chk_sync_all: assert property (@(posedge clk) disable iff (!resetn)
        ##2 sync2_reg == $past(in_raw, 2))
        else $error("host lines not delayed by two stages");

    // The captured number is the one decoded in the edge cycle itself.
    chk_edge_capture: assert property (@(posedge clk) disable iff (!resetn)
        strobe_edge |=> last_code_reg == $past(code_num))
        else $error("number not captured in the strobe edge cycle");

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (bus_req.addr == rsq_pkg::OFF_CTRL) begin
            rdata_next[rsq_pkg::CTRL_ENABLE_BIT] = enable_reg;
        end else if (bus_req.addr == rsq_pkg::OFF_STATUS) begin
            rdata_next[7:0] = running;
            rdata_next[rsq_pkg::STATUS_QUEUED_LSB +: 8] = queued_reg;
        end else if (bus_req.addr == rsq_pkg::OFF_LAST) begin
            rdata_next[9:0] = last_code_reg;
        end else if (bus_req.addr >= rsq_pkg::OFF_APP_BASE && bus_req.addr <= rsq_pkg::OFF_APP_LAST
                     && bus_req.addr[1:0] == 2'h0) begin
            rdata_next[9:0] = current_reg[bus_req.addr[4:2]];
            rdata_next[rsq_pkg::APP_NEXT_LSB +: 10] = next_reg[bus_req.addr[4:2]];
        end
    end

    // Read data stands only in the cycle after the strobe.
    // Clearing outside the slot keeps a stale word from passing for a fresh read.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            bus_rdata <= rdata_next;
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    chk_read_slot: assert property (@(posedge clk) disable iff (!resetn)
        !bus_req.rd |=> bus_rdata == 32'h0000_0000)
        else $error("read data outside its slot");

    // Register port checks; software writes reach only the control register.
    chk_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
        bus_req.wr && bus_req.addr == rsq_pkg::OFF_CTRL
        |=> enable_reg == $past(bus_req.wdata[rsq_pkg::CTRL_ENABLE_BIT]))
        else $error("control write did not land");

    chk_ro_ignore: assert property (@(posedge clk) disable iff (!resetn)
        !(bus_req.wr && bus_req.addr == rsq_pkg::OFF_CTRL) |=> $stable(enable_reg))
        else $error("enable changed without a control write");

    chk_ctrl_read: assert property (@(posedge clk) disable iff (!resetn)
        bus_req.rd && bus_req.addr == rsq_pkg::OFF_CTRL
        |=> bus_rdata[31:1] == 31'h0 && bus_rdata[0] == $past(enable_reg))
        else $error("control read does not match enable");

    chk_status_read: assert property (@(posedge clk) disable iff (!resetn)
        bus_req.rd && bus_req.addr == rsq_pkg::OFF_STATUS
        |=> bus_rdata == {16'h0000, $past(queued_reg), $past(running)})
        else $error("status read does not match applicator state");

    chk_last_read: assert property (@(posedge clk) disable iff (!resetn)
        bus_req.rd && bus_req.addr == rsq_pkg::OFF_LAST
        |=> bus_rdata == {22'h00_0000, $past(last_code_reg)})
        else $error("last captured number read back wrong");

    chk_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
        bus_req.rd && bus_req.addr > rsq_pkg::OFF_APP_LAST |=> bus_rdata == 32'h0000_0000)
        else $error("unmapped address read nonzero");

endmodule

// [verif/rsq_host_model.sv]
// Purpose: Host controller that drives the discrete select, mask, strobe, run and halt lines.
// Assumes: Lines are plain levels that rest low; the bench calls the tasks from its own sequence.
// Notes: Pulses are held a few cycles only, since the device acts on the rising edge alone.
`timescale 1ns/1ps
module rsq_host_model #(
    parameter int HOLD = 4
) (
    // Clock
    input wire logic clk,
    // Discrete lines towards the device
    output logic [8:0] recipe_code_input,
    output logic [7:0] applicator_mask_input,
    output logic recipe_latch_pulse,
    output logic [7:0] run_pulse_input,
    output logic [7:0] halt_pulse_input
);
    // All lines rest low, as they do when the host releases them.
    initial begin
        recipe_code_input = '0;
        applicator_mask_input = '0;
        recipe_latch_pulse = 1'b0;
        run_pulse_input = '0;
        halt_pulse_input = '0;
    end

    // Select and mask settle well before the strobe and outlast it, so the sample is clean.
    task automatic enter(input logic [8:0] code, input logic [7:0] mask);
        @(posedge clk);
        recipe_code_input <= code;
        applicator_mask_input <= mask;
        repeat (3) @(posedge clk);
        recipe_latch_pulse <= 1'b1;
        repeat (HOLD) @(posedge clk);
        recipe_latch_pulse <= 1'b0;
        @(posedge clk);
        recipe_code_input <= '0;
        applicator_mask_input <= '0;
        repeat (4) @(posedge clk);
    endtask

    // Run and halt are pulses held past the synchroniser before returning low.
    task automatic pulse(input logic is_run, input logic [7:0] m);
        @(posedge clk);
        if (is_run) begin
            run_pulse_input <= m;
        end else begin
            halt_pulse_input <= m;
        end
        repeat (HOLD) @(posedge clk);
        run_pulse_input <= '0;
        halt_pulse_input <= '0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// [verif/rsq_recipe_select_queue_tb.sv]
// Purpose: Self-checking bench for the recipe select queue.
// Assumes: 20 MHz clock, reset low for 12 cycles, host lines from the host model.
// Notes: Expected numbers come from the line weights, never from the device.
`timescale 1ns/1ps
module rsq_recipe_select_queue_tb;
    localparam int W[9] = '{1, 2, 4, 8, 10, 20, 40, 80, 100};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    rsq_pkg::rsq_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata;
    logic [8:0] code;
    logic [7:0] mask, run_p, halt_p;
    logic [7:0] aux = '0;
    logic strobe;
    rsq_pkg::rsq_app_status_t [7:0] app_status;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;

    // Clock at 50 ns period.
    always #25 clk = ~clk;

    rsq_host_model host_u (.clk(clk), .recipe_code_input(code), .applicator_mask_input(mask),
        .recipe_latch_pulse(strobe), .run_pulse_input(run_p), .halt_pulse_input(halt_p));

    rsq_recipe_select_queue dut_u (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .recipe_code_input(code), .applicator_mask_input(mask), .recipe_latch_pulse(strobe),
        .run_pulse_input(run_p), .halt_pulse_input(halt_p), .aux_mode_active(aux),
        .app_status(app_status));

    // A hang is cut short well beyond the length of the whole sequence.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_app(input int i, input logic r, input logic q, input logic [9:0] cur);
        chk({29'h0, app_status[i].running, app_status[i].queued}, {29'h0, r, q});
        chk({22'h0, app_status[i].current}, {22'h0, cur});
    endtask

    // Expected number: the sum of the weights of the high lines.
    function automatic logic [9:0] wsum(input logic [8:0] c);
        int s;
        s = 0;
        for (int k = 0; k < 9; k++) if (c[k]) s += W[k];
        return 10'(s);
    endfunction

    // The read data stand only in the cycle after the strobe, so it is sampled there.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        d = bus_rdata;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic t_reset();
        bus_rd(8'h00, rd);
        chk(rd, 32'h0000_0001);
        for (int i = 0; i < 8; i++) chk_app(i, 1'b0, 1'b0, 10'h000);
    endtask

    // Each line alone, then all nine at once to two idle applicators.
    task automatic t_weights();
        for (int i = 0; i < 9; i++) begin
            host_u.enter(9'(1 << i), 8'(1 << (i % 8)));
            chk_app(i % 8, 1'b0, 1'b0, 10'(W[i]));
        end
        host_u.enter(9'h1ff, 8'h05);
        chk_app(0, 1'b0, 1'b0, wsum(9'h1ff));
        chk_app(2, 1'b0, 1'b0, 10'd265);
        chk_app(1, 1'b0, 1'b0, 10'd2);
    endtask

    // Queue filling, overwrite, halt and promotion on applicator 1.
    task automatic t_queue();
        host_u.pulse(1'b1, 8'h02);
        chk_app(1, 1'b1, 1'b0, 10'd2);
        host_u.enter(9'h047, 8'h02);
        chk_app(1, 1'b1, 1'b1, 10'd2);
        chk({22'h0, app_status[1].next}, {22'h0, wsum(9'h047)});
        host_u.enter(9'h054, 8'h02);
        chk({22'h0, app_status[1].next}, 32'd54);
        host_u.pulse(1'b0, 8'h02);
        chk_app(1, 1'b0, 1'b1, 10'd2);
        host_u.pulse(1'b1, 8'h02);
        chk_app(1, 1'b1, 1'b0, 10'd54);
        host_u.pulse(1'b0, 8'h02);
        host_u.pulse(1'b1, 8'h02);
        chk_app(1, 1'b1, 1'b0, 10'd54);
        bus_rd(8'h04, rd);
        chk(rd, 32'h0000_0002);
        bus_rd(8'h24, rd);
        chk(rd & 32'h0000_03ff, 32'd54);
    endtask

    // An idle applicator in an auxiliary mode counts as executing and queues.
    task automatic t_aux();
        @(posedge clk);
        aux <= 8'h08;
        host_u.enter(9'h063, 8'h08);
        chk_app(3, 1'b0, 1'b1, 10'd8);
        chk({22'h0, app_status[3].next}, 32'd63);
        @(posedge clk);
        aux <= 8'h00;
    endtask

    // Entry disable, read-only status and an unmapped address.
    task automatic t_enable();
        bus_wr(8'h00, 32'h0000_0000);
        host_u.enter(9'h022, 8'h10);
        chk_app(4, 1'b0, 1'b0, 10'd10);
        bus_wr(8'h00, 32'h0000_0001);
        bus_wr(8'h04, 32'hffff_ffff);
        bus_rd(8'h04, rd);
        chk(rd, 32'h0000_0802);
        bus_rd(8'h2c, rd);
        chk(rd, 32'h003f_0008);
        bus_rd(8'hfc, rd);
        chk(rd, 32'h0000_0000);
        host_u.enter(9'h022, 8'h10);
        chk_app(4, 1'b0, 1'b0, 10'd22);
        bus_rd(8'h08, rd);
        chk(rd, 32'h0000_0016);
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_weights();
        t_queue();
        t_aux();
        t_enable();
        print_verdict();
    end
endmodule
